//--- hw/tcoc_chan.sv
// one compare output channel: waveform action and pin override
`timescale 1ns/10ps
`default_nettype none
`include "tcoc_params.svh"

module tcoc_chan
    import tcoc_pkg::*;
#(
    parameter bit IS_CHAN_A = 1'b0
) (
    input  wire logic            clk_sys,     // system clock
    input  wire logic            rst_sync_n,  // synchronised reset
    input  wire logic            tick,        // timer clock enable
    input  wire tcoc_wave_mode_t wave_mode,   // full four-bit mode
    input  wire tcoc_out_mode_t  out_mode,    // channel output mode
    input  wire logic            match,       // compare match
    input  wire logic            at_bottom,   // counter at bottom
    input  wire logic            at_top,      // counter at top
    input  wire logic            count_up,    // counting upward
    input  wire logic            eq_top,      // compare value is top
    input  wire logic            eq_bottom,   // compare value is bottom
    input  wire logic            port_data,   // normal port output
    input  wire logic            port_dir,    // data direction bit
    output logic                 cmp_out,     // compare output level
    output logic                 pin_out,     // pin output value
    output logic                 pin_oe_n     // pin driver enable, low on
);

    // ********************************************
    // mode decode
    // ********************************************
    tcoc_mode_class_t mode_class;
    logic             toggle_ok;
    logic             connected;
    logic             upper_set;
    logic             is_toggle;
    logic             cmp_q;
    logic             cmp_d;

    assign mode_class =
        (wave_mode == `TCOC_WM_NORMAL || wave_mode == `TCOC_WM_CTC_OCR ||
         wave_mode == `TCOC_WM_CTC_ICR) ? TCOC_MC_NONPWM :
        ((wave_mode >= `TCOC_WM_FAST8 && wave_mode <= `TCOC_WM_FAST10) ||
         wave_mode == `TCOC_WM_FAST_ICR ||
         wave_mode == `TCOC_WM_FAST_OCR) ? TCOC_MC_FAST :
        ((wave_mode >= `TCOC_WM_PC8 && wave_mode <= `TCOC_WM_PC10) ||
         (wave_mode >= `TCOC_WM_PFC_ICR && wave_mode <= `TCOC_WM_PC_OCR)) ?
        TCOC_MC_DUAL : TCOC_MC_RSVD;

    assign toggle_ok =
        (mode_class == TCOC_MC_NONPWM) ||
        (IS_CHAN_A && wave_mode == `TCOC_WM_FAST_OCR) ||
        (IS_CHAN_A && (wave_mode == `TCOC_WM_PFC_OCR ||
                       wave_mode == `TCOC_WM_PC_OCR));

    assign is_toggle = (out_mode == `TCOC_OM_TOGGLE);
    assign upper_set = out_mode[1];
    // zero field, or a toggle the mode does not allow, leaves the port
    assign connected = (out_mode != `TCOC_OM_OFF) &&
                       !(is_toggle && !toggle_ok);

    // ********************************************
    // next output level
    // ********************************************
    always_comb begin
        cmp_d = cmp_q;
        if (tick) begin
            case (mode_class)
                TCOC_MC_NONPWM: begin
                    if (match && is_toggle) begin
                        cmp_d = ~cmp_q;
                    end else if (match && upper_set) begin
                        cmp_d = out_mode[0];
                    end
                end
                TCOC_MC_FAST: begin
                    if (is_toggle && toggle_ok && match) begin
                        cmp_d = ~cmp_q;
                    end else if (upper_set && at_bottom) begin
                        cmp_d = ~out_mode[0];
                    end else if (upper_set && match && !eq_top) begin
                        cmp_d = out_mode[0];
                    end
                end
                TCOC_MC_DUAL: begin
                    if (is_toggle && toggle_ok && match) begin
                        cmp_d = ~cmp_q;
                    end else if (upper_set && at_bottom && eq_bottom) begin
                        cmp_d = out_mode[0];
                    end else if (upper_set && at_top && eq_top) begin
                        cmp_d = ~out_mode[0];
                    end else if (upper_set && match) begin
                        // up: 10 low, 11 high; down: opposite
                        cmp_d = count_up ? out_mode[0]
                                         : ~out_mode[0];
                    end
                end
                default: begin
                    cmp_d = cmp_q;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            cmp_q <= 1'b0;
        end else begin
            cmp_q <= cmp_d;
        end
    end

    // ********************************************
    // pin override
    // ********************************************
    assign cmp_out  = cmp_q;
    assign pin_out  = connected ? cmp_q : port_data;
    assign pin_oe_n = ~port_dir;

endmodule // tcoc_chan

`default_nettype wire

//--- hw/tcoc_params.svh
// constants for the timer compare output control block
`ifndef TCOC_PARAMS_SVH
`define TCOC_PARAMS_SVH

// **************************************************
// register addresses (data space) and io offsets
// **************************************************
`define TCOC_IO_SPAN_LO      8'h00
`define TCOC_IO_SPAN_HI      8'h3f
`define TCOC_DATA_ADD        8'h20
`define TCOC_EXT_SPACE_LO    8'h60
`define TCOC_T1_CTRL_A_OFS   8'h2f
`define TCOC_T3_CTRL_A_OFS   8'h8b
`define TCOC_CTRL_A_RESET    8'h00

// **************************************************
// field positions
// **************************************************
`define TCOC_CHAN_A_HI       7
`define TCOC_CHAN_A_LO       6
`define TCOC_CHAN_B_HI       5
`define TCOC_CHAN_B_LO       4
`define TCOC_CHAN_C_HI       3
`define TCOC_CHAN_C_LO       2
`define TCOC_WAVE_LOW_HI     1
`define TCOC_WAVE_LOW_LO     0

// **************************************************
// waveform mode numbers
// **************************************************
`define TCOC_WM_NORMAL       4'h0
`define TCOC_WM_PC8          4'h1
`define TCOC_WM_PC10         4'h3
`define TCOC_WM_CTC_OCR      4'h4
`define TCOC_WM_FAST8        4'h5
`define TCOC_WM_FAST10       4'h7
`define TCOC_WM_PFC_ICR      4'h8
`define TCOC_WM_PFC_OCR      4'h9
`define TCOC_WM_PC_OCR       4'hb
`define TCOC_WM_CTC_ICR      4'hc
`define TCOC_WM_RESERVED     4'hd
`define TCOC_WM_FAST_ICR     4'he
`define TCOC_WM_FAST_OCR     4'hf

// **************************************************
// output mode field values
// **************************************************
`define TCOC_OM_OFF          2'h0
`define TCOC_OM_TOGGLE       2'h1
`define TCOC_OM_CLEAR        2'h2
`define TCOC_OM_SET          2'h3

`endif

//--- hw/tcoc_pkg.sv
// types for the timer compare output control block
package tcoc_pkg;

    typedef enum logic [3:0] {
        TCOC_MC_NONPWM = 4'h1,
        TCOC_MC_FAST   = 4'h2,
        TCOC_MC_DUAL   = 4'h4,
        TCOC_MC_RSVD   = 4'h8
    } tcoc_mode_class_t;

    typedef logic [1:0] tcoc_out_mode_t;
    typedef logic [3:0] tcoc_wave_mode_t;

endpackage

//--- hw/tcoc_top.sv
// control register a of two 16-bit timers and their compare outputs
//
// Summary of operation
// - channel a, b, c output mode fields sit at bits 7:6, 5:4, 3:2
// - bits 1:0 hold the two low waveform mode bits
// - nonzero output mode routes compare output onto the pin, except 01 where the mode allows no toggle
// - pin driver enabled only when the direction bit says output
// - output mode zero leaves the pin under normal port control
// - non-pwm: 01 toggles, 10 clears, 11 sets on compare match
// - fast pwm 01 toggles channel a only in mode 15, else off
// - fast pwm 10: low on match, high at bottom
// - fast pwm 11: high on match, low at bottom
// - fast pwm: compare equal top with upper bit ignores match
// - dual-slope 01 toggles channel a only in modes 9 or 11
// - dual-slope 10: low on up-count match, high on down-count match
// - dual-slope 11: high on up-count match, low on down-count match
// - four-bit mode from register b high bits; classes non-pwm/fast/dual/reserved
// - dual-slope 10: compare at bottom gives steady low, at top steady high; 11 the reverse
`timescale 1ns/10ps
`default_nettype none
`include "tcoc_params.svh"

module tcoc_top
    import tcoc_pkg::*;
#(
    parameter int NUM_TIMERS = 2,
    parameter int NUM_CHAN   = 3
) (
    input  wire logic        clk_sys,         // 100 mhz i/o clock
    input  wire logic        rst_n,           // async reset, active low
    input  wire logic [7:0]  bus_addr,        // data-space address
    input  wire logic        bus_wr,          // write strobe
    input  wire logic        bus_rd,          // read strobe
    input  wire logic [7:0]  bus_wdata,       // write data
    output logic      [7:0]  bus_rdata,       // read data, registered
    input  wire logic [1:0]  t1_wave_mode_hi, // timer1 mode bits 3:2
    input  wire logic [1:0]  t3_wave_mode_hi, // timer3 mode bits 3:2
    input  wire logic [1:0]  timer_tick,      // clock enable per timer
    input  wire logic [1:0]  at_bottom,       // counter at bottom
    input  wire logic [1:0]  at_top,          // counter at top
    input  wire logic [1:0]  count_up,        // counting upward
    input  wire logic [5:0]  cmp_match,       // match, timer*3+chan
    input  wire logic [5:0]  cmp_eq_top,      // compare value is top
    input  wire logic [5:0]  cmp_eq_bottom,   // compare value is bottom
    input  wire logic [5:0]  port_data,       // normal port levels
    input  wire logic [5:0]  port_dir,        // direction bits
    output logic      [5:0]  cmp_out,         // compare output levels
    output logic      [5:0]  pin_out,         // pin output values
    output logic      [5:0]  pin_oe_n,        // pin enables, low drives
    output logic      [3:0]  t1_wave_mode,    // timer1 four-bit mode
    output logic      [3:0]  t3_wave_mode     // timer3 four-bit mode
);

    // ********************************************
    // elaboration checks
    // ********************************************
    generate
        if (NUM_TIMERS != 2) begin : g_bad_timers
            $error("tcoc_top serves exactly two timers");
        end
        if (NUM_CHAN != 3) begin : g_bad_chans
            $error("tcoc_top serves exactly three channels per timer");
        end
        // timer1 has to stay within reach of the io port instructions
        if (`TCOC_T1_CTRL_A_OFS > `TCOC_IO_SPAN_HI) begin : g_t1_io
            $error("timer1 control a lies outside the io span");
        end
        // its data address must not spill into extended space
        if (`TCOC_T1_CTRL_A_OFS + `TCOC_DATA_ADD >=
            `TCOC_EXT_SPACE_LO) begin : g_t1_data
            $error("timer1 data address runs into extended space");
        end
        // timer3 sits past the io span, data access only
        if (`TCOC_T3_CTRL_A_OFS < `TCOC_EXT_SPACE_LO) begin : g_t3_ext
            $error("timer3 control a must lie in extended space");
        end
        // each mode field is an adjacent bit pair
        if (`TCOC_CHAN_A_HI != `TCOC_CHAN_A_LO + 1 ||
            `TCOC_CHAN_B_HI != `TCOC_CHAN_B_LO + 1 ||
            `TCOC_CHAN_C_HI != `TCOC_CHAN_C_LO + 1) begin : g_bad_field
            $error("output mode fields must be two adjacent bits");
        end
        // mode fields and the low mode bits must not overlap
        if (`TCOC_CHAN_C_LO <= `TCOC_WAVE_LOW_HI ||
            `TCOC_WAVE_LOW_HI != `TCOC_WAVE_LOW_LO + 1) begin : g_bad_low
            $error("low mode bits must sit below the mode fields");
        end
    endgenerate

    // ********************************************
    // reset release
    // ********************************************
    // internal reset lifts two edges after the pin rises
    logic rst_meta_q;
    logic rst_sync_q;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end

    // ********************************************
    // address decode
    // ********************************************
    // timer1 sits in io space, so its data address carries the offset
    localparam logic [7:0] T1_ADDR = `TCOC_T1_CTRL_A_OFS +
                                     `TCOC_DATA_ADD;
    // timer3 lies in extended space, printed address is the data address
    localparam logic [7:0] T3_ADDR = `TCOC_T3_CTRL_A_OFS;

    logic t1_sel;
    logic t3_sel;
    logic t1_wr;
    logic t3_wr;

    assign t1_sel = (bus_addr == T1_ADDR);
    assign t3_sel = (bus_addr == T3_ADDR);
    assign t1_wr  = bus_wr && t1_sel;
    assign t3_wr  = bus_wr && t3_sel;

    // ********************************************
    // control registers a
    // ********************************************
    logic [7:0] t1_ctrl_a_q;
    logic [7:0] t3_ctrl_a_q;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;

    always_ff @(posedge clk_sys or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            t1_ctrl_a_q <= `TCOC_CTRL_A_RESET;
            t3_ctrl_a_q <= `TCOC_CTRL_A_RESET;
        end else begin
            if (t1_wr) begin
                t1_ctrl_a_q <= bus_wdata;
            end
            if (t3_wr) begin
                t3_ctrl_a_q <= bus_wdata;
            end
        end
    end

    assign rdata_d = !bus_rd ? rdata_q :
                     t1_sel  ? t1_ctrl_a_q :
                     t3_sel  ? t3_ctrl_a_q : 8'h00;

    always_ff @(posedge clk_sys or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign bus_rdata = rdata_q;

    // ********************************************
    // field extraction
    // ********************************************
    tcoc_out_mode_t  out_mode [6];
    tcoc_wave_mode_t wave_mode [2];

    assign out_mode[0] = t1_ctrl_a_q[`TCOC_CHAN_A_HI:`TCOC_CHAN_A_LO];
    assign out_mode[1] = t1_ctrl_a_q[`TCOC_CHAN_B_HI:`TCOC_CHAN_B_LO];
    assign out_mode[2] = t1_ctrl_a_q[`TCOC_CHAN_C_HI:`TCOC_CHAN_C_LO];
    assign out_mode[3] = t3_ctrl_a_q[`TCOC_CHAN_A_HI:`TCOC_CHAN_A_LO];
    assign out_mode[4] = t3_ctrl_a_q[`TCOC_CHAN_B_HI:`TCOC_CHAN_B_LO];
    assign out_mode[5] = t3_ctrl_a_q[`TCOC_CHAN_C_HI:`TCOC_CHAN_C_LO];

    assign wave_mode[0] = {t1_wave_mode_hi,
        t1_ctrl_a_q[`TCOC_WAVE_LOW_HI:`TCOC_WAVE_LOW_LO]};
    assign wave_mode[1] = {t3_wave_mode_hi,
        t3_ctrl_a_q[`TCOC_WAVE_LOW_HI:`TCOC_WAVE_LOW_LO]};

    assign t1_wave_mode = wave_mode[0];
    assign t3_wave_mode = wave_mode[1];

    // ********************************************
    // channels
    // ********************************************
    generate
        for (genvar gi = 0; gi < NUM_TIMERS * NUM_CHAN; gi++) begin : g_ch
            localparam int TI = gi / NUM_CHAN;
            tcoc_chan #(
                .IS_CHAN_A ((gi % NUM_CHAN) == 0)
            ) u_chan (
                .clk_sys    (clk_sys),
                .rst_sync_n (rst_sync_q),
                .tick       (timer_tick[TI]),
                .wave_mode  (wave_mode[TI]),
                .out_mode   (out_mode[gi]),
                .match      (cmp_match[gi]),
                .at_bottom  (at_bottom[TI]),
                .at_top     (at_top[TI]),
                .count_up   (count_up[TI]),
                .eq_top     (cmp_eq_top[gi]),
                .eq_bottom  (cmp_eq_bottom[gi]),
                .port_data  (port_data[gi]),
                .port_dir   (port_dir[gi]),
                .cmp_out    (cmp_out[gi]),
                .pin_out    (pin_out[gi]),
                .pin_oe_n   (pin_oe_n[gi])
            );
        end
    endgenerate

endmodule // tcoc_top

`default_nettype wire

//--- tb/tcoc_load_model.sv
// external loads on the six compare output pins
`timescale 1ns/10ps
`default_nettype none

module tcoc_load_model (
    input  wire logic       clk_sys,  // clock
    input  wire logic [5:0] pin_out,  // pin values
    input  wire logic [5:0] pin_oe_n, // low drives
    output logic      [5:0] pin_level // level at load
);
    logic [5:0] float_q = 6'h15;

    // undriven pins wander every cycle
    always @(posedge clk_sys) float_q <= ~float_q;
    assign pin_level = (pin_out & ~pin_oe_n) | (float_q & pin_oe_n);
endmodule // tcoc_load_model
`default_nettype wire

//--- tb/tcoc_top_asserts.sv
// concurrent checks on the compare output control ports
`timescale 1ns/10ps
`default_nettype none

module tcoc_top_asserts (
    input wire logic       clk_sys,         // clock
    input wire logic       rst_n,           // async reset
    input wire logic [7:0] bus_addr,        // address
    input wire logic       bus_wr,          // write
    input wire logic       bus_rd,          // read
    input wire logic [7:0] bus_wdata,       // write data
    input wire logic [7:0] bus_rdata,       // read data
    input wire logic [1:0] t1_wave_mode_hi, // mode high
    input wire logic [1:0] timer_tick,      // enables
    input wire logic [1:0] at_bottom,       // bottom
    input wire logic [1:0] at_top,          // top
    input wire logic [1:0] count_up,        // direction
    input wire logic [5:0] cmp_match,       // matches
    input wire logic [5:0] cmp_eq_top,      // compare at top
    input wire logic [5:0] port_dir,        // direction bits
    input wire logic [5:0] cmp_out,         // levels
    input wire logic [5:0] pin_out,         // pin values
    input wire logic [5:0] pin_oe_n,        // pin enables
    input wire logic [3:0] t1_wave_mode,    // timer1 mode
    input wire logic [3:0] t3_wave_mode     // timer3 mode
);
    // ****************************************
    // shadow registers and mode classes
    // ****************************************
    logic [7:0] sh1_q;
    logic [7:0] sh3_q;
    wire t1_fast = t1_wave_mode inside {4'h5, 4'h6, 4'h7, 4'he, 4'hf};
    wire t3_fast = t3_wave_mode inside {4'h5, 4'h6, 4'h7, 4'he, 4'hf};
    wire t1_dual = t1_wave_mode inside {[4'h1:4'h3], [4'h8:4'hb]};

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sh1_q <= 8'h00;
            sh3_q <= 8'h00;
        end else if (bus_wr && bus_addr == 8'h4f) begin
            sh1_q <= bus_wdata;
        end else if (bus_wr && bus_addr == 8'h8b) begin
            sh3_q <= bus_wdata;
        end
    end

    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    sequence t1_bot_s;
        timer_tick[0] && t1_fast && at_bottom[0];
    endsequence
    sequence t1_dual_s;
        timer_tick[0] && t1_dual && !at_bottom[0] && !at_top[0];
    endsequence

    oe_follow_a: assert property (pin_oe_n == ~port_dir)
        else $error("pin enable does not follow direction");
    mode_join_a: assert property (t1_wave_mode[3:2] == t1_wave_mode_hi)
        else $error("mode high bits wrong");
    write_low_a: assert property (bus_wr && bus_addr == 8'h4f
        |=> t1_wave_mode[1:0] == $past(bus_wdata[1:0]))
        else $error("mode low bits not written");
    read_back_a: assert property (bus_rd && !bus_wr && bus_addr == 8'h8b
        |=> bus_rdata == $past(sh3_q))
        else $error("read data wrong");
    fast_set_a: assert property (t1_bot_s ##0 sh1_q[7:6] == 2'h2
        |=> cmp_out[0])
        else $error("fast set at bottom missing");
    fast_inv_a: assert property (timer_tick[1] && t3_fast && at_bottom[1]
        && sh3_q[5:4] == 2'h3 |=> !cmp_out[4])
        else $error("fast clear at bottom missing");
    top_skip_a: assert property (timer_tick[0] && t1_fast && !at_bottom[0]
        && sh1_q[3] && cmp_eq_top[2] |=> $stable(cmp_out[2]))
        else $error("match at top not ignored");
    dual_up_a: assert property (t1_dual_s ##0 (cmp_match[0] && count_up[0]
        && sh1_q[7:6] == 2'h3) |=> cmp_out[0])
        else $error("up count set missing");
    dual_down_a: assert property (t1_dual_s ##0 (cmp_match[1]
        && !count_up[0] && sh1_q[5:4] == 2'h2) |=> cmp_out[1])
        else $error("down count set missing");
    toggle_a: assert property (timer_tick[1] && t3_wave_mode == 4'hf
        && sh3_q[7:6] == 2'h1 && cmp_match[3] |=> cmp_out[3] != $past(cmp_out[3]))
        else $error("toggle missing");
    hold_idle_a: assert property (!timer_tick[0] |=> $stable(cmp_out[2:0]))
        else $error("output moved without tick");
    pin_pick_a: assert property (sh1_q[7:6] == 2'h2 && t1_wave_mode != 4'hd
        |-> pin_out[0] == cmp_out[0])
        else $error("compare output not on pin");
endmodule // tcoc_top_asserts

bind tcoc_top tcoc_top_asserts tcoc_top_asserts_inst (
    .clk_sys(clk_sys), .rst_n(rst_n), .bus_addr(bus_addr), .bus_wr(bus_wr),
    .bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
    .t1_wave_mode_hi(t1_wave_mode_hi), .timer_tick(timer_tick),
    .at_bottom(at_bottom), .at_top(at_top), .count_up(count_up),
    .cmp_match(cmp_match), .cmp_eq_top(cmp_eq_top), .port_dir(port_dir),
    .cmp_out(cmp_out), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .t1_wave_mode(t1_wave_mode), .t3_wave_mode(t3_wave_mode));
`default_nettype wire

//--- tb/tcoc_top_tb.sv
// self-checking bench for the compare output control block
`timescale 1ns/10ps
`default_nettype none

module tcoc_top_tb;
    logic       clk_sys = 1'b0;
    logic       rst_n = 1'b0;
    logic       bus_wr = 1'b0, bus_rd = 1'b0;
    logic [7:0] bus_addr = 8'h00, bus_wdata = 8'h00, bus_rdata;
    logic [1:0] t1_wave_mode_hi = 2'h0, t3_wave_mode_hi = 2'h0;
    logic [1:0] timer_tick = 2'h0, at_bottom = 2'h0, count_up = 2'h0;
    logic [1:0] at_top = 2'h0;
    logic [5:0] cmp_match = 6'h00, cmp_eq_top = 6'h00, cmp_eq_bottom = 6'h00;
    logic [5:0] port_data = 6'h00, port_dir = 6'h3f;
    logic [5:0] cmp_out, pin_out, pin_oe_n, pin_level;
    logic [3:0] t1_wave_mode, t3_wave_mode;
    int         bad_count = 0, samples_checked = 0, cycles = 0;

    tcoc_top tcoc_top_inst (
        .clk_sys(clk_sys), .rst_n(rst_n), .bus_addr(bus_addr),
        .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_wdata(bus_wdata),
        .bus_rdata(bus_rdata), .t1_wave_mode_hi(t1_wave_mode_hi),
        .t3_wave_mode_hi(t3_wave_mode_hi), .timer_tick(timer_tick),
        .at_bottom(at_bottom), .at_top(at_top), .count_up(count_up),
        .cmp_match(cmp_match), .cmp_eq_top(cmp_eq_top),
        .cmp_eq_bottom(cmp_eq_bottom), .port_data(port_data),
        .port_dir(port_dir), .cmp_out(cmp_out), .pin_out(pin_out),
        .pin_oe_n(pin_oe_n), .t1_wave_mode(t1_wave_mode),
        .t3_wave_mode(t3_wave_mode));
    tcoc_load_model tcoc_load_model_inst (.clk_sys(clk_sys),
        .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_level(pin_level));

    // ****************************************
    // access tasks and checks
    // ****************************************
    always #5 clk_sys = ~clk_sys;

    task automatic conclude();
        $display("checked %0d mismatched %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 3000) begin
            bad_count++;
            conclude();
        end
    end

    task automatic chk(input string nm, input logic [7:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, d);
        @(posedge clk_sys);
        bus_addr <= a;
        bus_wdata <= d;
        bus_wr <= 1'b1;
        @(posedge clk_sys);
        bus_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, exp);
        @(posedge clk_sys);
        bus_addr <= a;
        bus_rd <= 1'b1;
        @(posedge clk_sys);
        bus_rd <= 1'b0;
        #1;
        chk("bus_rdata", bus_rdata, exp);
    endtask

    // one timer event held for a single tick edge
    task automatic ev(input logic [1:0] tk, bt, up, input logic [5:0] m, eb);
        @(posedge clk_sys);
        timer_tick <= tk;
        at_bottom <= bt;
        count_up <= up;
        cmp_match <= m;
        cmp_eq_top <= 6'h04;
        cmp_eq_bottom <= eb;
        @(posedge clk_sys);
        timer_tick <= 2'h0;
        at_bottom <= 2'h0;
        cmp_match <= 6'h00;
        cmp_eq_bottom <= 6'h00;
        #1;
    endtask

    initial begin
        repeat (12) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
        rd(8'h4f, 8'h00);
        rd(8'h8b, 8'h00);
        wr(8'h50, 8'hff);
        rd(8'h50, 8'h00);
        @(posedge clk_sys);
        t1_wave_mode_hi <= 2'h1;
        t3_wave_mode_hi <= 2'h3;
        port_data <= 6'h02;
        wr(8'h4f, 8'h99);
        wr(8'h8b, 8'h7f);
        rd(8'h4f, 8'h99);
        rd(8'h8b, 8'h7f);
        chk("t1_wave_mode", {4'h0, t1_wave_mode}, 8'h05);
        chk("t3_wave_mode", {4'h0, t3_wave_mode}, 8'h0f);
        ev(2'h3, 2'h3, 2'h0, 6'h00, 6'h00);
        chk("pin_out", {2'h0, pin_out}, 8'h07);
        ev(2'h3, 2'h0, 2'h0, 6'h3f, 6'h00);
        chk("pin_out", {2'h0, pin_out}, 8'h3e);
        chk("cmp_out", {2'h0, cmp_out}, 8'h3c);
        chk("pin_level", {2'h0, pin_level}, 8'h3e);
        port_dir <= 6'h0a;
        #1;
        chk("pin_oe_n", {2'h0, pin_oe_n}, 8'h35);
        chk("pin_level", {2'h0, pin_level & 6'h0a}, 8'h0a);
        @(posedge clk_sys);
        port_dir <= 6'h3f;
        t1_wave_mode_hi <= 2'h2;
        t3_wave_mode_hi <= 2'h2;
        port_data <= 6'h14;
        wr(8'h4f, 8'he1);
        wr(8'h8b, 8'h5b);
        ev(2'h3, 2'h0, 2'h3, 6'h3f, 6'h00);
        chk("pin_out", {2'h0, pin_out}, 8'h15);
        ev(2'h3, 2'h0, 2'h0, 6'h3f, 6'h00);
        chk("pin_out", {2'h0, pin_out}, 8'h3e);
        ev(2'h1, 2'h1, 2'h0, 6'h00, 6'h03);
        chk("pin_out", {2'h0, pin_out}, 8'h3d);
        @(posedge clk_sys);
        timer_tick <= 2'h1;
        at_top <= 2'h1;
        cmp_eq_top <= 6'h03;
        @(posedge clk_sys);
        timer_tick <= 2'h0;
        at_top <= 2'h0;
        #1;
        chk("pin_out", {2'h0, pin_out}, 8'h3e);
        @(posedge clk_sys);
        t1_wave_mode_hi <= 2'h0;
        t3_wave_mode_hi <= 2'h1;
        port_data <= 6'h08;
        wr(8'h4f, 8'h6c);
        wr(8'h8b, 8'h38);
        ev(2'h1, 2'h0, 2'h0, 6'h3f, 6'h00);
        chk("pin_out", {2'h0, pin_out & 6'h2f}, 8'h2d);
        ev(2'h0, 2'h0, 2'h0, 6'h3f, 6'h00);
        chk("pin_out", {2'h0, pin_out & 6'h2f}, 8'h2d);
        ev(2'h3, 2'h0, 2'h0, 6'h3f, 6'h00);
        chk("pin_out", {2'h0, pin_out}, 8'h1c);
        conclude();
    end
endmodule // tcoc_top_tb
`default_nettype wire
